// File: design/watchdog_timer.sv
// Sleep-aware watchdog timer with APB register access
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire wdt_pkg::apb_req_t apb_req_in,
  output wdt_pkg::apb_rsp_t      apb_rsp_out,
  input  wire logic [1:0]        wdt_mode_config_in,
  input  wire logic              sleep_in,
  input  wire logic              clear_watchdog_instr_in,
  input  wire logic              osc_fail_in,
  input  wire logic              low_freq_internal_osc_in,
  output logic                   reset_req_out,
  output logic                   wake_out,
  output logic                   timeout_flag_out,
  output logic                   powerdown_flag_out
);

  typedef enum logic [1:0]
  {
    ST_RUN   = 2'h0,
    ST_SLEEP = 2'h1,
    ST_EXIT  = 2'h3
  } wdt_st_t;

  typedef struct packed
  {
    wdt_st_t     st;
    logic [18:0] count;
    logic        sw_en;
    logic [4:0]  ps;
    logic        to_flag;
    logic        pdown_flag;
    logic [31:0] rdata;
    logic        slverr;
    logic        reset_req;
    logic        wake;
  } wdt_state_t;

  wdt_state_t state_r;
  wdt_state_t state_nxt;

  logic              lf_edge;
  logic              tick;
  logic              active;
  logic              clear;
  logic              hit;
  logic [18:0]       period;
  wdt_pkg::wdt_mode_t mode;

  // Decode whether the counter may run in the given mode
  function automatic logic wdt_active
  (
    input wdt_pkg::wdt_mode_t m,
    input logic               en,
    input logic               asleep
  );
    logic a;
    a = 1'b0;
    case (m)
      wdt_pkg::MODE_ON:      a = 1'b1;
      wdt_pkg::MODE_NOSLEEP: a = ~asleep;
      wdt_pkg::MODE_SW:      a = en;
      default:               a = 1'b0;
    endcase
    return a;
  endfunction

  // Timeout length in milliseconds; codes beyond the top clamp to 2**18 ms
  function automatic logic [18:0] period_of
  (
    input logic [4:0] ps
  );
    logic [4:0] p;
    p = (ps > wdt_pkg::PS_MAX) ? wdt_pkg::PS_MAX : ps;
    return 19'h00001 << p;
  endfunction

  // Read data for a register offset
  function automatic logic [31:0] read_of
  (
    input logic [7:0] addr,
    input wdt_state_t s
  );
    logic [31:0] d;
    d = '0;
    if (addr == wdt_pkg::OFS_CTRL)
    begin
      d[wdt_pkg::CTRL_EN_BIT] = s.sw_en;
      d[wdt_pkg::CTRL_PS_LSB +: wdt_pkg::PS_W] = s.ps;
    end
    else if (addr == wdt_pkg::OFS_STATUS)
    begin
      d[wdt_pkg::STAT_TO_BIT] = s.to_flag;
      d[wdt_pkg::STAT_PDOWN_BIT] = s.pdown_flag;
    end
    else if (addr == wdt_pkg::OFS_COUNT)
    begin
      d[wdt_pkg::COUNT_W-1:0] = s.count;
    end
    return d;
  endfunction

  function automatic logic mapped
  (
    input logic [7:0] addr
  );
    logic m;
    m = 1'b0;
    if (addr == wdt_pkg::OFS_CTRL)
    begin
      m = 1'b1;
    end
    else if (addr == wdt_pkg::OFS_STATUS)
    begin
      m = 1'b1;
    end
    else if (addr == wdt_pkg::OFS_COUNT)
    begin
      m = 1'b1;
    end
    return m;
  endfunction

  // Slow oscillator is asynchronous to clk_in
  osc_edge_sync osc_edge_sync_i
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .osc_in     (low_freq_internal_osc_in),
    .edge_out   (lf_edge)
  );

  ms_tick_gen ms_tick_gen_i
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .lf_edge_in (lf_edge),
    .clear_in   (clear),
    .tick_out   (tick)
  );

  assign mode   = wdt_pkg::wdt_mode_t'(wdt_mode_config_in);
  assign active = wdt_active(mode, state_r.sw_en, state_r.st == ST_SLEEP);
  assign period = period_of(state_r.ps);

  // Sleep entry, sleep exit and the exit-settle state all clear the count
  assign clear = ~active
               | clear_watchdog_instr_in | osc_fail_in
               | ((state_r.st == ST_RUN) & sleep_in)
               | ((state_r.st == ST_SLEEP) & ~sleep_in)
               | (state_r.st == ST_EXIT);

  assign hit = tick & ~clear & (state_r.count + 19'h00001 >= period);

  always_comb
  begin
    state_nxt           = state_r;
    state_nxt.reset_req = 1'b0;
    state_nxt.wake      = 1'b0;

    case (state_r.st)
      ST_RUN:
      begin
        if (sleep_in)
        begin
          state_nxt.st = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (!sleep_in)
        begin
          state_nxt.st = ST_EXIT;
        end
      end
      ST_EXIT:
      begin
        state_nxt.st = sleep_in ? ST_SLEEP : ST_RUN;
      end
      default:
      begin
        state_nxt.st = ST_RUN;
      end
    endcase

    // Only the millisecond tick advances the count; no system divider term
    if (clear)
    begin
      state_nxt.count = '0;
    end
    else if (hit)
    begin
      state_nxt.count = '0;
    end
    else if (tick)
    begin
      state_nxt.count = state_r.count + 19'h00001;
    end

    // Register writes land in the access phase; flag clears come first
    if (apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite)
    begin
      if (apb_req_in.paddr == wdt_pkg::OFS_CTRL)
      begin
        state_nxt.sw_en = apb_req_in.pwdata[wdt_pkg::CTRL_EN_BIT];
        state_nxt.ps    = apb_req_in.pwdata[wdt_pkg::CTRL_PS_LSB +: wdt_pkg::PS_W];
      end
      else if (apb_req_in.paddr == wdt_pkg::OFS_STATUS)
      begin
        if (apb_req_in.pwdata[wdt_pkg::STAT_TO_BIT])
        begin
          state_nxt.to_flag = 1'b0;
        end
        if (apb_req_in.pwdata[wdt_pkg::STAT_PDOWN_BIT])
        begin
          state_nxt.pdown_flag = 1'b0;
        end
      end
    end

    // A timeout beats a same-cycle flag clear
    if (hit)
    begin
      state_nxt.to_flag = 1'b1;
      if (state_r.st == ST_SLEEP)
      begin
        state_nxt.wake       = 1'b1;
        state_nxt.pdown_flag = 1'b1;
      end
      else
      begin
        state_nxt.reset_req = 1'b1;
      end
    end

    // Read data is captured in the setup phase so the access phase can finish at once
    if (apb_req_in.psel && !apb_req_in.penable)
    begin
      state_nxt.rdata  = apb_req_in.pwrite ? 32'h00000000 : read_of(apb_req_in.paddr, state_r);
      state_nxt.slverr = ~mapped(apb_req_in.paddr);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r       <= '0;
      state_r.st    <= ST_RUN;
      state_r.sw_en <= wdt_pkg::EN_RESET;
      state_r.ps    <= wdt_pkg::PS_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign apb_rsp_out = '{prdata:  state_r.rdata,
                         pready:  1'b1,
                         pslverr: state_r.slverr & apb_req_in.psel & apb_req_in.penable};

  assign reset_req_out      = state_r.reset_req;
  assign wake_out           = state_r.wake;
  assign timeout_flag_out   = state_r.to_flag;
  assign powerdown_flag_out = state_r.pdown_flag;

  a_mode_off_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode == wdt_pkg::MODE_OFF |=> state_r.count == '0 && !reset_req_out && !wake_out)
    else $error("count moved or fired in mode 00");

  a_sw_enable_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode == wdt_pkg::MODE_SW && !state_r.sw_en |=> state_r.count == '0)
    else $error("count not held with software enable low");

  a_sleep_entry_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_r.st == ST_RUN && sleep_in |=> state_r.count == '0 && state_r.st == ST_SLEEP)
    else $error("count not cleared on sleep entry");

  a_sleep_exit_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_r.st == ST_SLEEP && !sleep_in |=> state_r.count == '0 ##1 state_r.count == '0)
    else $error("count not cleared twice on sleep exit");

  a_instr_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clear_watchdog_instr_in || osc_fail_in |=> state_r.count == '0 && !reset_req_out)
    else $error("clear instruction or oscillator fail ignored");

  a_sleep_wakes: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hit && state_r.st == ST_SLEEP |=> wake_out && !reset_req_out && powerdown_flag_out)
    else $error("sleep timeout did not wake");

  a_awake_resets: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hit && state_r.st != ST_SLEEP |=> reset_req_out && !wake_out ##1 !reset_req_out)
    else $error("awake timeout reset request wrong");

  a_timeout_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hit |=> timeout_flag_out && state_r.count == '0)
    else $error("timeout flag not set");

  a_always_on: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode == wdt_pkg::MODE_ON && state_r.st == ST_SLEEP && sleep_in && tick
    && !clear_watchdog_instr_in && !osc_fail_in && !hit
    |=> state_r.count == $past(state_r.count) + 19'h00001)
    else $error("mode 11 did not count in sleep");

  a_nosleep_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode == wdt_pkg::MODE_NOSLEEP && state_r.st == ST_SLEEP |=> state_r.count == '0 && !wake_out)
    else $error("mode 10 ran during sleep");

  a_ps_default: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> state_r.ps == wdt_pkg::PS_RESET)
    else $error("period select not at two seconds after reset");

  c_awake_timeout: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_req_out);

  c_sleep_wake: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    wake_out ##[1:20] state_r.st == ST_EXIT);

  c_flag_race: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    hit && apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite);

endmodule
`default_nettype wire

// File: inc/wdt_pkg.sv
// Shared constants and carrier types for the sleep-aware watchdog
package wdt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_PS_LSB = 1;
  localparam int unsigned PS_W        = 5;
  localparam logic [4:0]  PS_RESET    = 5'h0b;
  localparam logic [4:0]  PS_MAX      = 5'h12;
  localparam logic        EN_RESET    = 1'b0;

  // Status register fields, write one to clear
  localparam int unsigned STAT_TO_BIT    = 0;
  localparam int unsigned STAT_PDOWN_BIT = 1;

  // Millisecond counter spans 2**18 ms
  localparam int unsigned COUNT_W = 19;

  // Base tick built from the slow oscillator
  localparam int unsigned LF_OSC_HZ   = 31000;
  localparam int unsigned BASE_TICK_US = 1000;
  localparam int unsigned LF_PER_TICK = LF_OSC_HZ * BASE_TICK_US / 1000000;
  localparam logic [4:0]  LF_TICK_LAST = 5'(LF_PER_TICK - 1);

  typedef enum logic [1:0]
  {
    MODE_OFF     = 2'h0,
    MODE_SW      = 2'h1,
    MODE_NOSLEEP = 2'h2,
    MODE_ON      = 2'h3
  } wdt_mode_t;

  typedef struct packed
  {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_t;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// File: design/osc_edge_sync.sv
// Three-stage synchroniser with rising-edge strobe for the slow oscillator
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic osc_in,
  output logic      edge_out
);

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    state_nxt.s1 = osc_in;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    // A change counts only once the two later stages agree
    if (state_r.s2 == state_r.s3)
    begin
      state_nxt.level = state_r.s2;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign edge_out = state_r.s2 & state_r.s3 & ~state_r.level;

endmodule
`default_nettype wire

// File: design/ms_tick_gen.sv
// Divides slow-oscillator edges down to the one millisecond base tick
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic lf_edge_in,
  input  wire logic clear_in,
  output logic      tick_out
);

  typedef struct packed
  {
    logic [4:0] div;
  } tick_state_t;

  tick_state_t state_r;
  tick_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    // Clearing also drops the partial millisecond
    if (clear_in)
    begin
      state_nxt.div = '0;
    end
    else if (lf_edge_in)
    begin
      state_nxt.div = tick_out ? 5'h00 : state_r.div + 5'h01;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign tick_out = lf_edge_in & ~clear_in & (state_r.div == wdt_pkg::LF_TICK_LAST);

endmodule
`default_nettype wire

// File: tb/core_model.sv
// Core model: issues clear strobes and sleep entry, leaves sleep on wake
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic go_sleep_in,
  input  wire logic clear_req_in,
  input  wire logic wake_in,
  output logic      sleep_out,
  output logic      clear_out
);
  logic go_q_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sleep_out <= 1'b0;
      clear_out <= 1'b0;
      go_q_r    <= 1'b0;
    end
    else
    begin
      go_q_r    <= go_sleep_in;
      clear_out <= clear_req_in;
      // Software must drop the request before sleeping again
      if (!go_sleep_in || wake_in)
        sleep_out <= 1'b0;
      else if (!go_q_r)
        sleep_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb/watchdog_timer_sleep_aware_tb.sv
// Self-checking bench for the sleep-aware watchdog
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_sleep_aware_tb;
  logic              clk_in;
  logic              reset_n_in;
  wdt_pkg::apb_req_t req;
  wdt_pkg::apb_rsp_t rsp;
  logic [1:0]        mode;
  logic              osc;
  logic              osc_fail;
  logic              go_sleep;
  logic              clear_req;
  logic              sleep;
  logic              clear;
  logic              reset_req;
  logic              wake;
  logic              to_flag;
  logic              pdown_flag;
  logic [31:0]       r;
  logic              err;
  int                n_fail = 0;
  int                check_count = 0;
  int                n_rr = 0;
  int                n_wk = 0;
  int                e;
  int                b;
  int                b2;
  // Per case: mode, enable, asleep, reset pulses, wake pulses
  localparam logic [5:0] CASES [10] = '{6'h32, 6'h35, 6'h22, 6'h24, 6'h1a,
                                        6'h1d, 6'h10, 6'h14, 6'h08, 6'h0c};

  watchdog_timer watchdog_timer_i
  (
    .clk_in                   (clk_in),
    .reset_n_in               (reset_n_in),
    .apb_req_in               (req),
    .apb_rsp_out              (rsp),
    .wdt_mode_config_in       (mode),
    .sleep_in                 (sleep),
    .clear_watchdog_instr_in  (clear),
    .osc_fail_in              (osc_fail),
    .low_freq_internal_osc_in (osc),
    .reset_req_out            (reset_req),
    .wake_out                 (wake),
    .timeout_flag_out         (to_flag),
    .powerdown_flag_out       (pdown_flag)
  );

  core_model core_model_i
  (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .go_sleep_in  (go_sleep),
    .clear_req_in (clear_req),
    .wake_in      (wake),
    .sleep_out    (sleep),
    .clear_out    (clear)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    if (reset_req === 1'b1)
      n_rr <= n_rr + 1;
    if (wake === 1'b1)
      n_wk <= n_wk + 1;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      n_fail++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge clk_in);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_in);
      if (rsp.pready === 1'b1)
        break;
    end
    r = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (i == 20)
    begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Slow oscillator runs only while a test asks for edges
  task automatic pulse(input int n);
    repeat (n)
    begin
      osc <= 1'b1;
      repeat (6) @(posedge clk_in);
      osc <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask

  // Counts oscillator edges until the next timeout pulse, bounded by max
  task automatic until_to(input int max);
    b = n_rr + n_wk;
    e = 0;
    while (n_rr + n_wk == b && e < max)
    begin
      pulse(1);
      e++;
    end
    // A timeout that never comes ends the run
    if (n_rr + n_wk == b)
    begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic clr();
    @(posedge clk_in);
    clear_req <= 1'b1;
    @(posedge clk_in);
    clear_req <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic slp(input logic s);
    @(posedge clk_in);
    go_sleep <= s;
    repeat (4) @(posedge clk_in);
  endtask

  initial
  begin
    reset_n_in = 1'b0;
    req = '0;
    mode = 2'h3;
    osc = 1'b0;
    osc_fail = 1'b0;
    go_sleep = 1'b0;
    clear_req = 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(wdt_pkg::OFS_CTRL, {26'h0, wdt_pkg::PS_RESET, wdt_pkg::EN_RESET});
    rd(wdt_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, 8'h0c, 32'hffffffff);
    check({31'h0, err}, 32'h1);
    wr(wdt_pkg::OFS_COUNT, 32'hffffffff);
    rd(wdt_pkg::OFS_COUNT, 32'h0);
    $display("test registers done");
    for (int ps = 0; ps < 3; ps++)
    begin
      wr(wdt_pkg::OFS_CTRL, 32'(ps) << 1);
      rd(wdt_pkg::OFS_CTRL, 32'(ps) << 1);
      clr();
      until_to(200);
      check(32'(e), 32'd31 << ps);
      check({30'h0, pdown_flag, to_flag}, 32'h1);
    end
    clr();
    pulse(93);
    rd(wdt_pkg::OFS_COUNT, 32'h3);
    wr(wdt_pkg::OFS_STATUS, 32'h3);
    rd(wdt_pkg::OFS_STATUS, 32'h0);
    wr(wdt_pkg::OFS_CTRL, 32'h0);
    clr();
    repeat (500) @(posedge clk_in);
    until_to(40);
    check(32'(e), 32'd31);
    // Two millisecond period so a sleeping count is seen before it expires
    wr(wdt_pkg::OFS_CTRL, 32'h2);
    slp(1'b1);
    pulse(40);
    rd(wdt_pkg::OFS_COUNT, 32'h1);
    slp(1'b0);
    rd(wdt_pkg::OFS_COUNT, 32'h0);
    $display("test period done");
    for (int i = 0; i < 10; i++)
    begin
      mode <= CASES[i][5:4];
      wr(wdt_pkg::OFS_CTRL, {31'h0, CASES[i][3]});
      clr();
      slp(CASES[i][2]);
      b = n_rr;
      b2 = n_wk;
      pulse(40);
      slp(1'b0);
      check(32'(n_rr - b), {31'h0, CASES[i][1]});
      check(32'(n_wk - b2), {31'h0, CASES[i][0]});
      rd(wdt_pkg::OFS_STATUS, {30'h0, CASES[i][0], |CASES[i][1:0]});
      wr(wdt_pkg::OFS_STATUS, 32'h3);
    end
    $display("test modes done");
    for (int k = 0; k < 6; k++)
    begin
      mode <= 2'h3;
      clr();
      pulse(20);
      b2 = n_rr + n_wk;
      case (k)
        0: clr();
        1:
        begin
          osc_fail <= 1'b1;
          slp(1'b0);
          osc_fail <= 1'b0;
        end
        2: slp(1'b1);
        3:
        begin
          slp(1'b1);
          slp(1'b0);
        end
        4:
        begin
          mode <= 2'h0;
          slp(1'b0);
          mode <= 2'h3;
        end
        default:
        begin
          mode <= 2'h2;
          slp(1'b1);
          slp(1'b0);
        end
      endcase
      pulse(20);
      check(32'(n_rr + n_wk - b2), 32'h0);
      until_to(40);
      check(32'(e), 32'd11);
      slp(1'b0);
    end
    $display("test clearing done");
    // Mid-run reset with a partial count and both flags set
    wr(wdt_pkg::OFS_CTRL, 32'h3);
    pulse(40);
    rd(wdt_pkg::OFS_COUNT, 32'h1);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(wdt_pkg::OFS_COUNT, 32'h0);
    rd(wdt_pkg::OFS_CTRL, {26'h0, wdt_pkg::PS_RESET, wdt_pkg::EN_RESET});
    rd(wdt_pkg::OFS_STATUS, 32'h0);
    $display("test reset done");
    test_done();
  end
endmodule
`default_nettype wire
